// File: pkg/serial_status_pkg.sv
// Constants for the serial channel status block: register map, field
// positions and reset values. Assumes 32-bit word-aligned AHB-Lite access.
package serial_status_pkg;

   // Byte offsets of the word registers
   localparam logic [7:0] STATUS_OFS = 8'h00;
   localparam logic [7:0] CONTROL_OFS = 8'h04;
   localparam logic [7:0] RX_HOLD_OFS = 8'h08;
   localparam logic [7:0] TX_HOLD_OFS = 8'h0c;

   // Status register fields
   localparam int TX_EMPTY_BIT = 7;
   localparam int RX_FULL_BIT = 6;
   localparam int OVERRUN_BIT = 5;
   localparam int FRAMING_BIT = 4;
   localparam int PARITY_BIT = 3;
   localparam int TX_DONE_BIT = 2;
   localparam int RX_STATION_BIT = 1;
   localparam int TX_STATION_BIT = 0;

   // Flags cleared by a read of 1 followed by a write of 0
   localparam logic [7:0] ARMED_MASK = 8'hf8;
   localparam logic [7:0] STATUS_RESET = 8'h84;

   // Control register fields
   localparam int RX_ON_BIT = 0;
   localparam int TX_ON_BIT = 1;
   localparam int SYNC_BIT = 2;
   localparam int MP_BIT = 3;
   localparam int PAR_ON_BIT = 4;
   localparam int PAR_ODD_BIT = 5;
   localparam int TWO_STOP_BIT = 6;
   localparam int SEVEN_BIT = 7;
   localparam logic [7:0] CONTROL_RESET = 8'h00;

   localparam logic [7:0] HOLD_RESET = 8'h00;
   localparam logic [7:0] TX_HOLD_RESET = 8'hff;

   // AHB-Lite encodings
   localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
   localparam logic HRESP_OKAY = 1'h0;

endpackage : serial_status_pkg

// File: hw/rx_frame_check.sv
// Checks one received asynchronous character for framing and parity faults.
// Assumes the receive shifter presents the character for one cycle.
`timescale 1ns/1ns
module rx_frame_check import serial_status_pkg::*; (
   input wire logic frame_done,
   input wire logic async_mode,
   input wire logic parity_on,
   input wire logic parity_odd,
   input wire logic char_seven,
   input wire logic [7:0] char_data,
   input wire logic char_parity,
   input wire logic stop_first,
   output logic framing_fault,
   output logic parity_fault
);

   logic [7:0] data_used;
   logic ones_odd;
   logic check_on;

   // Seven-bit characters leave the top bit out of the count
   assign data_used = char_seven ? {1'b0, char_data[6:0]} : char_data;
   assign ones_odd = ^{data_used, char_parity};
   assign check_on = frame_done & async_mode;

   // Only the first stop bit is looked at; a second one is never checked
   assign framing_fault = check_on & ~stop_first;
   assign parity_fault = check_on & parity_on & (ones_odd != parity_odd);

endmodule : rx_frame_check

// File: hw/serial_status.sv
// Status and holding registers of the serial channel with an AHB-Lite slave.
// Assumes the line-side shifters and the DMA controller run on clk_sys and
// signal their events as one-cycle pulses.
//
// The register offsets and register access over AHB-Lite were chosen for this implementation.
`timescale 1ns/1ns
module serial_status import serial_status_pkg::*; (
   input wire logic clk_sys,
   input wire logic resetn,
   // AHB-Lite slave
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic hreadyout,
   output logic hresp,
   output logic [31:0] hrdata,
   // Power control
   input wire logic standby,
   // Receive shifter
   input wire logic rx_frame_done,
   input wire logic [7:0] rx_frame_data,
   input wire logic rx_frame_parity,
   input wire logic rx_stop_first,
   input wire logic rx_frame_station,
   output logic rx_run,
   output logic [7:0] rx_holding_data,
   // Transmit shifter
   input wire logic tx_load,
   input wire logic tx_last_bit,
   output logic tx_run,
   output logic tx_station_bit,
   output logic [7:0] tx_holding_data,
   // DMA controller
   input wire logic dma_rx_read,
   input wire logic dma_tx_write,
   input wire logic [7:0] dma_tx_data,
   // Frame format for the shifters
   output logic sync_mode,
   output logic mp_format,
   output logic parity_on,
   output logic parity_odd,
   output logic two_stop,
   output logic char_seven
);

   // Bus pipeline
   logic wr_phase_q;
   logic rd_phase_q;
   logic [7:0] addr_q;
   logic take;

   // Registers
   logic [7:0] control_q;
   logic [7:0] rx_hold_q;
   logic [7:0] tx_hold_q;
   logic [7:0] armed_q;
   logic tx_empty_q;
   logic rx_full_q;
   logic overrun_q;
   logic framing_q;
   logic parity_q;
   logic tx_done_q;
   logic rx_station_q;
   logic tx_station_q;

   logic [7:0] status;
   logic [7:0] armed_d;
   logic [7:0] sw_clear;
   logic [7:0] rd_value;
   logic wr_status;
   logic wr_control;
   logic wr_tx_hold;
   logic rd_status;
   logic halted;
   logic rx_accept;
   logic rx_lost;
   logic rx_store;
   logic frame_fault;
   logic par_fault;
   logic rx_good;
   logic async_mode;
   logic tx_off_edge;

   logic tx_empty_d;
   logic rx_full_d;
   logic overrun_d;
   logic framing_d;
   logic parity_d;
   logic tx_done_d;
   logic rx_station_d;
   logic tx_station_d;
   logic [7:0] rx_hold_d;
   logic [7:0] tx_hold_d;
   logic [7:0] control_d;

   // ---------------- AHB-Lite address and data phase ----------------
   assign take = hsel & hready & (htrans == HTRANS_NONSEQ | htrans == 2'h3);

   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         wr_phase_q <= 1'b0;
         rd_phase_q <= 1'b0;
         addr_q <= 8'h00;
      end else begin
         wr_phase_q <= take & hwrite;
         rd_phase_q <= take & ~hwrite;
         if (take) begin
            addr_q <= haddr[7:0];
         end
      end
   end

   // Zero wait states, always OKAY
   assign hreadyout = 1'b1;
   assign hresp = HRESP_OKAY;

   assign wr_status = wr_phase_q & (addr_q == STATUS_OFS);
   assign wr_control = wr_phase_q & (addr_q == CONTROL_OFS);
   assign wr_tx_hold = wr_phase_q & (addr_q == TX_HOLD_OFS);
   assign rd_status = rd_phase_q & (addr_q == STATUS_OFS);

   // Bit order of the status word
   assign status = {tx_empty_q, rx_full_q, overrun_q, framing_q,
                    parity_q, tx_done_q, rx_station_q, tx_station_q};

   // Read mux; unmapped offsets read as zero
   assign rd_value = (addr_q == STATUS_OFS) ? status :
                     (addr_q == CONTROL_OFS) ? control_q :
                     (addr_q == RX_HOLD_OFS) ? rx_hold_q :
                     (addr_q == TX_HOLD_OFS) ? tx_hold_q : 8'h00;
   assign hrdata = rd_phase_q ? {24'h000000, rd_value} : 32'h00000000;

   // ---------------- Read-then-write-zero clearing ----------------
   // Each clearable flag remembers that software has seen it at 1
   genvar gi;
   generate
      for (gi = 0; gi < 8; gi++) begin : g_arm
         if (ARMED_MASK[gi]) begin : g_on
            assign sw_clear[gi] = wr_status & armed_q[gi] & ~hwdata[gi];
            assign armed_d[gi] = standby ? 1'b0 :
                                 sw_clear[gi] ? 1'b0 :
                                 (rd_status & status[gi]) ? 1'b1 :
                                 (armed_q[gi] & status[gi]);
         end else begin : g_off
            assign sw_clear[gi] = 1'b0;
            assign armed_d[gi] = 1'b0;
         end
      end
   endgenerate

   // ---------------- Control register ----------------
   assign control_d = standby ? CONTROL_RESET :
                      wr_control ? hwdata[7:0] : control_q;
   assign async_mode = ~control_q[SYNC_BIT];
   assign sync_mode = control_q[SYNC_BIT];
   assign mp_format = control_q[MP_BIT];
   assign parity_on = control_q[PAR_ON_BIT];
   assign parity_odd = control_q[PAR_ODD_BIT];
   assign two_stop = control_q[TWO_STOP_BIT];
   assign char_seven = control_q[SEVEN_BIT];
   assign tx_off_edge = control_q[TX_ON_BIT] & ~control_d[TX_ON_BIT];

   // ---------------- Receive side ----------------
   rx_frame_check u_check (
      .frame_done(rx_frame_done),
      .async_mode(async_mode),
      .parity_on(control_q[PAR_ON_BIT]),
      .parity_odd(control_q[PAR_ODD_BIT]),
      .char_seven(control_q[SEVEN_BIT]),
      .char_data(rx_frame_data),
      .char_parity(rx_frame_parity),
      .stop_first(rx_stop_first),
      .framing_fault(frame_fault),
      .parity_fault(par_fault)
   );

   // Any receive fault stops the receiver; sync mode also stops the sender
   assign halted = overrun_q | framing_q | parity_q;
   assign rx_run = control_q[RX_ON_BIT] & ~halted;
   assign tx_run = control_q[TX_ON_BIT] & ~(sync_mode & halted);

   assign rx_accept = rx_frame_done & rx_run;
   // A character arriving while the holding register is still full is lost
   assign rx_lost = rx_accept & rx_full_q;
   assign rx_store = rx_accept & ~rx_full_q;
   assign rx_good = rx_store & ~frame_fault & ~par_fault;

   // Faulty characters still land in the holding register
   assign rx_hold_d = standby ? HOLD_RESET :
                      rx_store ? rx_frame_data : rx_hold_q;

   // Fault flags: hardware set wins over a software clear; receiver-off
   // has no term here, so the flags keep their value
   assign framing_d = standby ? 1'b0 :
                      (rx_store & frame_fault) ? 1'b1 :
                      sw_clear[FRAMING_BIT] ? 1'b0 : framing_q;
   assign parity_d = standby ? 1'b0 :
                     (rx_store & par_fault) ? 1'b1 :
                     sw_clear[PARITY_BIT] ? 1'b0 : parity_q;
   assign overrun_d = standby ? 1'b0 :
                      rx_lost ? 1'b1 :
                      sw_clear[OVERRUN_BIT] ? 1'b0 : overrun_q;

   // Full is set only by a clean character
   assign rx_full_d = standby ? 1'b0 :
                      rx_good ? 1'b1 :
                      (sw_clear[RX_FULL_BIT] | dma_rx_read) ? 1'b0 :
                      rx_full_q;

   // Station bit follows stored async multiprocessor characters only
   assign rx_station_d = standby ? 1'b0 :
                         (rx_store & async_mode & mp_format) ? rx_frame_station :
                         rx_station_q;

   // ---------------- Transmit side ----------------
   // Holding register written by software or by the DMA controller
   assign tx_hold_d = standby ? TX_HOLD_RESET :
                      dma_tx_write ? dma_tx_data :
                      wr_tx_hold ? hwdata[7:0] : tx_hold_q;

   // Empty sets when the shifter takes the character or the sender is switched off
   assign tx_empty_d = standby ? 1'b1 :
                       (tx_load | tx_off_edge) ? 1'b1 :
                       (sw_clear[TX_EMPTY_BIT] | dma_tx_write) ? 1'b0 :
                       tx_empty_q;

   // Done clears with a software clear of Empty or a DMA write; its set terms win over clears
   assign tx_done_d = standby ? 1'b1 :
                      (tx_off_edge | (tx_last_bit & tx_empty_q)) ? 1'b1 :
                      (sw_clear[TX_EMPTY_BIT] | dma_tx_write) ? 1'b0 :
                      tx_done_q;

   // Software-written station bit for outgoing characters
   assign tx_station_d = standby ? 1'b0 :
                         wr_status ? hwdata[TX_STATION_BIT] : tx_station_q;

   // Appended only while an async multiprocessor character is going out
   assign tx_station_bit = tx_station_q & async_mode & mp_format &
                           ~tx_done_q & control_q[TX_ON_BIT];

   assign rx_holding_data = rx_hold_q;
   assign tx_holding_data = tx_hold_q;

   // ---------------- State registers ----------------
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         control_q <= CONTROL_RESET;
         rx_hold_q <= HOLD_RESET;
         tx_hold_q <= TX_HOLD_RESET;
         armed_q <= 8'h00;
      end else begin
         control_q <= control_d;
         rx_hold_q <= rx_hold_d;
         tx_hold_q <= tx_hold_d;
         armed_q <= armed_d;
      end
   end

   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         tx_empty_q <= STATUS_RESET[TX_EMPTY_BIT];
         rx_full_q <= STATUS_RESET[RX_FULL_BIT];
         overrun_q <= STATUS_RESET[OVERRUN_BIT];
         framing_q <= STATUS_RESET[FRAMING_BIT];
         parity_q <= STATUS_RESET[PARITY_BIT];
      end else begin
         tx_empty_q <= tx_empty_d;
         rx_full_q <= rx_full_d;
         overrun_q <= overrun_d;
         framing_q <= framing_d;
         parity_q <= parity_d;
      end
   end

   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         tx_done_q <= STATUS_RESET[TX_DONE_BIT];
         rx_station_q <= STATUS_RESET[RX_STATION_BIT];
         tx_station_q <= STATUS_RESET[TX_STATION_BIT];
      end else begin
         tx_done_q <= tx_done_d;
         rx_station_q <= rx_station_d;
         tx_station_q <= tx_station_d;
      end
   end

endmodule : serial_status

// File: sim/serial_status_chk.sv
// Concurrent checks on the ports of the serial status block.
// Assumes one clk_sys domain and resetn active low.
`timescale 1ns/1ns
module serial_status_chk import serial_status_pkg::*; (
   input wire logic clk_sys,
   input wire logic resetn,
   input wire logic hsel,
   input wire logic hready,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [31:0] hrdata,
   input wire logic standby,
   input wire logic rx_frame_done,
   input wire logic [7:0] rx_frame_data,
   input wire logic rx_frame_parity,
   input wire logic rx_stop_first,
   input wire logic rx_run,
   input wire logic [7:0] rx_holding_data,
   input wire logic tx_run,
   input wire logic tx_station_bit,
   input wire logic [7:0] tx_holding_data,
   input wire logic dma_tx_write,
   input wire logic [7:0] dma_tx_data,
   input wire logic sync_mode,
   input wire logic mp_format,
   input wire logic parity_on,
   input wire logic parity_odd,
   input wire logic char_seven
);
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!resetn);
   wire [7:0] par_data = char_seven ? {1'b0, rx_frame_data[6:0]} : rx_frame_data;
   wire par_bad = ^par_data ^ rx_frame_parity ^ parity_odd;
   wire take_rx = rx_frame_done & rx_run;
   sequence async_char;
      take_rx && !sync_mode && !standby;
   endsequence
   sequence rd_req;
      hsel && hready && htrans[1] && !hwrite;
   endsequence
   a_frame_stops_rx: assert property (async_char ##0 !rx_stop_first |=> !rx_run)
      else $error("framing fault left reception running");
   a_parity_stops_rx: assert property (async_char ##0 (parity_on && par_bad) |=> !rx_run)
      else $error("parity fault left reception running");
   a_halted_char_ignored: assert property (rx_frame_done && !rx_run && !standby
      |=> $stable(rx_holding_data))
      else $error("character taken while reception halted");
   a_hold_has_cause: assert property (!$stable(rx_holding_data) |-> $past(take_rx) || $past(standby))
      else $error("receive holding changed without a character");
   a_station_gated: assert property (tx_station_bit |-> tx_run && !sync_mode && mp_format)
      else $error("sent station bit outside async multiprocessor transmit");
   a_standby_resets: assert property (standby |=> rx_holding_data == HOLD_RESET
      && tx_holding_data == TX_HOLD_RESET && !rx_run && !tx_run && !tx_station_bit)
      else $error("standby did not restore reset values");
   a_dma_loads_tx: assert property (dma_tx_write && !standby
      |=> tx_holding_data == $past(dma_tx_data))
      else $error("dma write did not load transmit holding");
   a_read_upper_zero: assert property (rd_req |=> hrdata[31:8] == 24'h0)
      else $error("read data upper bits not zero");
   a_idle_data_zero: assert property (!rd_req |=> hrdata == 32'h0)
      else $error("read data outside a read data phase");
endmodule : serial_status_chk
bind serial_status serial_status_chk chk_u (.*);

// File: sim/serial_line_model.sv
// Line-side shifters: presents received characters and transmit events.
// Assumes its tasks are called from a process in step with clk_sys.
`timescale 1ns/1ns
module serial_line_model (
   input wire logic clk_sys,
   output logic rx_frame_done,
   output logic [7:0] rx_frame_data,
   output logic rx_frame_parity,
   output logic rx_stop_first,
   output logic rx_frame_station,
   output logic tx_load,
   output logic tx_last_bit
);
   initial begin
      {rx_frame_done, tx_load, tx_last_bit} = 3'h0;
      {rx_frame_data, rx_frame_parity, rx_stop_first, rx_frame_station} = 11'h2aa;
   end
   // Lines invert after the pulse so a stale character never looks valid
   task automatic send(input logic [7:0] d, input logic p, input logic s, input logic m);
      @(posedge clk_sys);
      {rx_frame_data, rx_frame_parity, rx_stop_first, rx_frame_station} <= {d, p, s, m};
      rx_frame_done <= 1'b1;
      @(posedge clk_sys);
      {rx_frame_data, rx_frame_parity, rx_stop_first, rx_frame_station} <= ~{d, p, s, m};
      rx_frame_done <= 1'b0;
      #1;
   endtask : send
   task automatic tx_event(input logic ld, input logic last);
      @(posedge clk_sys);
      {tx_load, tx_last_bit} <= {ld, last};
      @(posedge clk_sys);
      {tx_load, tx_last_bit} <= 2'h0;
      #1;
   endtask : tx_event
endmodule : serial_line_model

// File: sim/serial_rx_error_tx_end_status_tb.sv
// Self-checking bench for the serial status block over AHB-Lite.
// Assumes the line model and the checker bound to the design top.
`timescale 1ns/1ns
module serial_rx_error_tx_end_status_tb import serial_status_pkg::*; ();
   logic clk_sys = 1'b0;
   logic resetn = 1'b0;
   logic hwrite = 1'b0, standby = 1'b0, dma_rx_read = 1'b0, dma_tx_write = 1'b0;
   logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata;
   logic [1:0] htrans = 2'h0;
   logic [7:0] dma_tx_data = 8'h0, rx_frame_data, rx_holding_data, tx_holding_data;
   logic hreadyout, hresp, rx_run, tx_run, tx_station_bit, tx_load, tx_last_bit;
   logic rx_frame_done, rx_frame_parity, rx_stop_first, rx_frame_station;
   int num_errors = 0, comparisons = 0;
   always #5 clk_sys = ~clk_sys;
   serial_line_model lm (.*);
   serial_status dut_u (.*, .hsel(1'b1), .hsize(3'h2), .hready(hreadyout), .sync_mode(),
      .mp_format(), .parity_on(), .parity_odd(), .two_stop(), .char_seven());
   task automatic complete_run();
      $display("comparisons %0d mismatches %0d", comparisons, num_errors);
      if (num_errors == 0 && comparisons > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask : complete_run
   task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
      comparisons++;
      if (got !== exp) begin
         num_errors++;
         $display("wrong value %s expected %h seen %h", what, exp, got);
      end
   endtask : chk
   task automatic bus_edge();
      int n;
      n = 0;
      @(posedge clk_sys);
      while (hreadyout !== 1'b1) begin
         n++;
         if (n > 100) begin
            num_errors++;
            complete_run();
         end
         @(posedge clk_sys);
      end
   endtask : bus_edge
   task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d,
      output logic [7:0] r);
      haddr <= {24'h0, a};
      hwrite <= w;
      htrans <= HTRANS_NONSEQ;
      bus_edge();
      htrans <= 2'h0;
      hwdata <= {24'h0, d};
      bus_edge();
      r = hrdata[7:0];
   endtask : bus
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      logic [7:0] r;
      bus(1'b1, a, d, r);
   endtask : wr
   task automatic rchk(input logic [7:0] a, input logic [7:0] exp, input string what);
      logic [7:0] r;
      bus(1'b0, a, 8'h0, r);
      chk(what, exp, r);
   endtask : rchk
   task automatic dma(input logic rd, input logic w, input logic [7:0] d);
      @(posedge clk_sys);
      {dma_rx_read, dma_tx_write, dma_tx_data} <= {rd, w, d};
      @(posedge clk_sys);
      {dma_rx_read, dma_tx_write} <= 2'h0;
      #1;
   endtask : dma
   function automatic logic par_bad(input logic [7:0] d, input logic p, input logic odd);
      return (^d ^ p) != odd;
   endfunction : par_bad
   function automatic logic [7:0] rx_status(input logic fe, input logic pe);
      return {1'b1, ~(fe | pe), 1'b0, fe, pe, 3'b100};
   endfunction : rx_status
   initial begin
      logic [7:0] ctl, d;
      logic p, s, fe, pe;
      repeat (20) @(posedge clk_sys);
      resetn <= 1'b1;
      void'($urandom(12));
      rchk(STATUS_OFS, STATUS_RESET, "status");
      rchk(CONTROL_OFS, CONTROL_RESET, "control");
      rchk(TX_HOLD_OFS, TX_HOLD_RESET, "tx hold");
      rchk(8'h10, 8'h00, "unmapped");
      chk("hresp", {7'h0, HRESP_OKAY}, {7'h0, hresp});
      wr(STATUS_OFS, 8'hff);
      rchk(STATUS_OFS, 8'h85, "status ones");
      wr(STATUS_OFS, 8'h80);
      $display("test registers done");
      for (int i = 0; i < 12; i++) begin
         ctl = {1'b0, 3'($urandom), 4'h1};
         d = 8'($urandom);
         p = 1'($urandom);
         s = (i != 0) && ($urandom % 3 != 0);
         fe = ~s;
         pe = ctl[PAR_ON_BIT] && par_bad(d, p, ctl[PAR_ODD_BIT]);
         wr(CONTROL_OFS, ctl);
         lm.send(d, p, s, 1'b0);
         chk("rx data", d, rx_holding_data);
         rchk(STATUS_OFS, rx_status(fe, pe), "status char");
         if (fe | pe) begin
            chk("rx run", 8'h0, {7'h0, rx_run});
            lm.send(~d, p, 1'b1, 1'b0);
            chk("rx data held", d, rx_holding_data);
            wr(STATUS_OFS, 8'hf8);
            wr(CONTROL_OFS, 8'h00);
            rchk(STATUS_OFS, rx_status(fe, pe), "status rx off");
            wr(STATUS_OFS, 8'he0);
            rchk(STATUS_OFS, STATUS_RESET, "status cleared");
         end else begin
            dma(1'b1, 1'b0, 8'h0);
         end
      end
      $display("test reception done");
      wr(CONTROL_OFS, 8'h05);
      lm.send(8'h5a, 1'b1, 1'b0, 1'b0);
      rchk(STATUS_OFS, 8'hc4, "status sync");
      dma(1'b1, 1'b0, 8'h0);
      wr(CONTROL_OFS, 8'h09);
      lm.send(8'h33, 1'b0, 1'b1, 1'b1);
      rchk(STATUS_OFS, 8'hc6, "station rx");
      dma(1'b1, 1'b0, 8'h0);
      wr(CONTROL_OFS, 8'h08);
      rchk(STATUS_OFS, 8'h86, "station held");
      $display("test station done");
      wr(STATUS_OFS, 8'h81);
      wr(CONTROL_OFS, 8'h0a);
      dma(1'b0, 1'b1, 8'hc3);
      chk("tx hold", 8'hc3, tx_holding_data);
      chk("tx station", 8'h1, {7'h0, tx_station_bit});
      rchk(STATUS_OFS, 8'h03, "status dma");
      lm.tx_event(1'b1, 1'b0);
      lm.tx_event(1'b0, 1'b1);
      chk("tx station idle", 8'h0, {7'h0, tx_station_bit});
      rchk(STATUS_OFS, 8'h87, "status end");
      wr(STATUS_OFS, 8'h01);
      rchk(STATUS_OFS, 8'h03, "status empty clr");
      wr(CONTROL_OFS, 8'h08);
      rchk(STATUS_OFS, 8'h87, "status tx off");
      wr(CONTROL_OFS, 8'h0e);
      dma(1'b0, 1'b1, 8'h3c);
      chk("tx station sync", 8'h0, {7'h0, tx_station_bit});
      $display("test transmit done");
      @(posedge clk_sys);
      standby <= 1'b1;
      @(posedge clk_sys);
      standby <= 1'b0;
      rchk(STATUS_OFS, STATUS_RESET, "status standby");
      $display("test standby done");
      complete_run();
   end
endmodule : serial_rx_error_tx_end_status_tb
